// >>> logic/adcc_top.sv
// Overview of operation
// (RL1) per-conversion DMA enable issues a DMA request after each conversion
// (RL2) sequence DMA enable issues a DMA request when a sequence ends
// (RL3) all-channel watchdog bit makes every channel's result checked
// (RL4) four-bit field picks the one channel the watchdog checks
// (RL5) justification bit puts result in bits 11:0 or 15:4
// (RL6) unread result is overwritten or new result dropped per policy bit
// (RL7) four-bit input select chooses the converted input in single-channel modes
// (RL8) writing one clears the accumulator; the clear bit reads zero
// (RL9) accumulate enable adds every result into the accumulator
// (RL10) multiple-conversion modes perform count plus one conversions (sequences in sequence-multiple) then stop
// (RL11) software keeps reserved bits at their reset value
// (RL12) both control registers reset to zero
// (RL13) the count applies to modes single-multiple and sequence-multiple
// (RL14) watchdog compares against twelve-bit high and low limits
// (RL15) an out-of-window watched result sets a software-visible flag
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.svh"
module adcc_top
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // converter core
  input wire logic conv_done_i,
  input wire logic [3:0] conv_chan_i,
  input wire logic [11:0] conv_data_i,
  input wire logic seq_done_i,
  output logic core_run_o,
  output logic [2:0] conv_mode_o,
  output logic [3:0] input_select_o,
  // dma and interrupt
  output logic dma_conv_req_o,
  output logic dma_seq_req_o,
  output logic irq_o
);
  adcc_top_t s, n;
  logic wr_fire;
  logic rd_take;
  logic acc_clr;
  logic tick;
  logic fin;
  logic watch_hit;
  logic overrun;
  logic [15:0] result;
  logic unread;
  logic [31:0] rd_val;
  logic [`ADCC_IRQ_W-1:0] events;

  // byte-lane merge of a wishbone write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[8*i +: 8] = wdat[8*i +: 8];
    end
    return r;
  endfunction

  // address decode shared by reads and writes
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction

  // a write lands on the edge that samples ack; a read is captured one edge
  // earlier, where its side effects also happen so no event slips between
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && s.ack;
  assign rd_take = wb_cyc_i && wb_stb_i && !wb_we_i && !s.ack;
  assign acc_clr = wr_fire && hit(wb_adr_i, `ADCC_OFS_CTRL_B) && wb_sel_i[1]
                   && wb_dat_i[`ADCC_B_ACC_CLR];

  // single-channel modes count conversions, sequence modes count sequences
  assign tick = (s.mode[2] || s.mode == ADCC_M_SEQ_CONT) ? seq_done_i : conv_done_i;

  adcc_result u_result (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .store_i(conv_done_i),
    .data_i(conv_data_i),
    .align_left_i(s.ctrl_a[`ADCC_A_ALIGN]), // RL5
    .discard_i(s.ctrl_a[`ADCC_A_DISCARD]), // RL6
    .read_i(rd_take && hit(wb_adr_i, `ADCC_OFS_RESULT)),
    .result_o(result),
    .unread_o(unread),
    .overrun_o(overrun)
  );

  adcc_watch u_watch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .watch_all_i(s.ctrl_a[`ADCC_A_WATCH_ALL]), // RL3
    .single_en_i(s.single_en),
    .select_i(s.ctrl_a[`ADCC_A_WSEL_HI:`ADCC_A_WSEL_LO]), // RL4
    .high_i(s.high),
    .low_i(s.low),
    .valid_i(conv_done_i),
    .chan_i(conv_chan_i),
    .data_i(conv_data_i),
    .hit_o(watch_hit)
  );

  // read multiplexer; reserved bits read as zero, clear bit always zero
  always_comb
  begin
    rd_val = 32'h0;
    if (hit(wb_adr_i, `ADCC_OFS_CTRL_A))
      rd_val = s.ctrl_a;
    else if (hit(wb_adr_i, `ADCC_OFS_CTRL_B))
      rd_val = s.ctrl_b; // RL8
    else if (hit(wb_adr_i, `ADCC_OFS_MODE))
    begin
      rd_val[`ADCC_M_MODE_HI:`ADCC_M_MODE_LO] = s.mode;
      rd_val[`ADCC_M_SINGLE_EN] = s.single_en;
      rd_val[`ADCC_M_BUSY] = s.run;
    end
    else if (hit(wb_adr_i, `ADCC_OFS_HIGH))
      rd_val[11:0] = s.high;
    else if (hit(wb_adr_i, `ADCC_OFS_LOW))
      rd_val[11:0] = s.low;
    else if (hit(wb_adr_i, `ADCC_OFS_RESULT))
      rd_val[15:0] = result;
    else if (hit(wb_adr_i, `ADCC_OFS_ACCUM))
      rd_val = s.accum;
    else if (hit(wb_adr_i, `ADCC_OFS_STATUS))
      rd_val[`ADCC_IRQ_W-1:0] = s.status;
    else if (hit(wb_adr_i, `ADCC_OFS_MASK))
      rd_val[`ADCC_IRQ_W-1:0] = s.mask;
  end

  // next-state logic for bus, registers, sequencer, dma and interrupt
  always_comb
  begin
    n = s;
    fin = 1'b0;
    n.ack = wb_cyc_i && wb_stb_i && !s.ack;
    if (rd_take)
      n.rdata = rd_val;

    // register writes; reserved bits are never stored
    if (wr_fire)
    begin
      if (hit(wb_adr_i, `ADCC_OFS_CTRL_A))
        n.ctrl_a = merge(s.ctrl_a, wb_dat_i, wb_sel_i) & `ADCC_A_MASK;
      else if (hit(wb_adr_i, `ADCC_OFS_CTRL_B))
        n.ctrl_b = merge(s.ctrl_b, wb_dat_i, wb_sel_i) & `ADCC_B_MASK;
      else if (hit(wb_adr_i, `ADCC_OFS_MODE) && wb_sel_i[0])
        n.mode = wb_dat_i[`ADCC_M_MODE_HI:`ADCC_M_MODE_LO];
      else if (hit(wb_adr_i, `ADCC_OFS_HIGH))
        n.high = 12'(merge({20'h0, s.high}, wb_dat_i, wb_sel_i)); // RL14
      else if (hit(wb_adr_i, `ADCC_OFS_LOW))
        n.low = 12'(merge({20'h0, s.low}, wb_dat_i, wb_sel_i));
      else if (hit(wb_adr_i, `ADCC_OFS_MASK) && wb_sel_i[0])
        n.mask = wb_dat_i[`ADCC_IRQ_W-1:0];
      if (hit(wb_adr_i, `ADCC_OFS_MODE) && wb_sel_i[1])
        n.single_en = wb_dat_i[`ADCC_M_SINGLE_EN];
    end

    // accumulator: a clear in the same cycle as an accumulated result leaves just that result
    if (acc_clr)
      n.accum = 32'h0; // RL8
    if (conv_done_i && s.ctrl_b[`ADCC_B_ACC_EN])
      n.accum = n.accum + {20'h0, conv_data_i}; // RL9

    // conversion run sequencer
    case (s.state)
      ADCC_IDLE:
      begin
        if (wr_fire && hit(wb_adr_i, `ADCC_OFS_MODE) && wb_sel_i[0]
            && wb_dat_i[`ADCC_M_START])
        begin
          n.state = ADCC_RUN;
          n.run = 1'b1;
          n.remain = s.ctrl_b[`ADCC_B_CNT_HI:`ADCC_B_CNT_LO]; // RL10
        end
      end
      ADCC_RUN:
      begin
        if (wr_fire && hit(wb_adr_i, `ADCC_OFS_MODE) && wb_sel_i[0]
            && wb_dat_i[`ADCC_M_STOP])
        begin
          n.state = ADCC_IDLE;
          n.run = 1'b0;
        end
        else if (tick)
        begin
          if (s.mode == ADCC_M_SINGLE_MULTI || s.mode == ADCC_M_SEQ_MULTI) // RL13
          begin
            if (s.remain == 8'h00)
              fin = 1'b1; // RL10
            else
              n.remain = s.remain - 8'h01;
          end
          else if (s.mode != ADCC_M_SINGLE_CONT && s.mode != ADCC_M_SEQ_CONT)
            fin = 1'b1;
          if (fin)
          begin
            n.state = ADCC_IDLE;
            n.run = 1'b0;
          end
        end
      end
      default:
      begin
        n.state = ADCC_IDLE;
        n.run = 1'b0;
      end
    endcase

    // dma requests, one cycle per event
    n.dma_conv = conv_done_i && s.ctrl_a[`ADCC_A_DMA_CONV]; // RL1
    n.dma_seq = seq_done_i && s.ctrl_a[`ADCC_A_DMA_SEQ]; // RL2

    // sticky status: a status read clears what it returned, a new event wins
    events = '0;
    events[`ADCC_IRQ_CONV] = conv_done_i;
    events[`ADCC_IRQ_SEQ] = seq_done_i;
    events[`ADCC_IRQ_WATCH] = watch_hit; // RL15
    events[`ADCC_IRQ_OVR] = overrun && unread;
    events[`ADCC_IRQ_FIN] = fin;
    if (rd_take && hit(wb_adr_i, `ADCC_OFS_STATUS))
      n.status = '0;
    n.status = n.status | events;
    n.irq = |(n.status & n.mask);
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.ctrl_a <= `ADCC_CTRL_A_RST; // RL12
      s.ctrl_b <= `ADCC_CTRL_B_RST; // RL12
      s.high <= `ADCC_HIGH_RST;
      s.low <= `ADCC_LOW_RST;
      s.state <= ADCC_IDLE;
    end
    else
      s <= n;
  end

  // outputs straight from flops
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdata;
  assign core_run_o = s.run;
  assign conv_mode_o = s.mode;
  assign input_select_o = s.ctrl_a[`ADCC_A_INSEL_HI:`ADCC_A_INSEL_LO]; // RL7
  assign dma_conv_req_o = s.dma_conv;
  assign dma_seq_req_o = s.dma_seq;
  assign irq_o = s.irq;

  sequence s_clear_write;
    acc_clr;
  endsequence
  sequence s_start_write;
    wr_fire && hit(wb_adr_i, `ADCC_OFS_MODE) && wb_sel_i[0] && wb_dat_i[`ADCC_M_START];
  endsequence

  AST_DMA_CONV: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
    conv_done_i |=> dma_conv_req_o == $past(s.ctrl_a[`ADCC_A_DMA_CONV]))
    else $error("per-conversion dma request wrong");
  AST_DMA_SEQ: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
    !seq_done_i |=> !dma_seq_req_o)
    else $error("sequence dma request without sequence end");
  AST_DMA_SEQ_EN: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
    seq_done_i && s.ctrl_a[`ADCC_A_DMA_SEQ] |=> dma_seq_req_o)
    else $error("sequence dma request missing");
  AST_WATCH_ALL_FLAG: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
    conv_done_i && s.ctrl_a[`ADCC_A_WATCH_ALL] && conv_data_i > s.high
      |=> ##1 s.status[`ADCC_IRQ_WATCH])
    else $error("all-channel watchdog did not flag");
  AST_ACC_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
    s_clear_write ##0 !conv_done_i |=> s.accum == 32'h0)
    else $error("accumulator not cleared");
  AST_ACC_ADD: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
    conv_done_i && s.ctrl_b[`ADCC_B_ACC_EN] && !acc_clr
      |=> s.accum == $past(s.accum) + {20'h0, $past(conv_data_i)})
    else $error("accumulator did not add result");
  AST_ACC_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
    !s.ctrl_b[`ADCC_B_ACC_EN] && !wr_fire |=> $stable(s.accum))
    else $error("accumulator moved while disabled");
  AST_COUNT_END: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
    s.state == ADCC_RUN && s.mode == ADCC_M_SINGLE_MULTI && conv_done_i && !wr_fire
      && s.remain == 8'h00 |=> !core_run_o && s.status[`ADCC_IRQ_FIN])
    else $error("multiple-conversion run did not stop at count");
  AST_CLR_READS_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
    wb_ack_o && !wb_we_i && hit(wb_adr_i, `ADCC_OFS_CTRL_B) |-> !wb_dat_o[`ADCC_B_ACC_CLR])
    else $error("clear bit read back as one");
  AST_RESET_ZERO: assert property (@(posedge clk_i) // RL12
    rst_i |=> s.ctrl_a == 32'h0 && s.ctrl_b == 32'h0 && !dma_conv_req_o)
    else $error("control registers not zero after reset");

  // bus handshake, dma, field writes, run counting, status and accumulator checks
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_DMA_CONV_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
    !conv_done_i |=> !dma_conv_req_o)
    else $error("per-conversion dma request without conversion");
  AST_DMA_SEQ_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
    seq_done_i && !s.ctrl_a[`ADCC_A_DMA_SEQ] |=> !dma_seq_req_o)
    else $error("sequence dma request while disabled");
  AST_INSEL_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
    wr_fire && hit(wb_adr_i, `ADCC_OFS_CTRL_A) && wb_sel_i[0]
      |=> input_select_o == $past(wb_dat_i[`ADCC_A_INSEL_HI:`ADCC_A_INSEL_LO]))
    else $error("input select not taken from write");
  AST_WSEL_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
    wr_fire && hit(wb_adr_i, `ADCC_OFS_CTRL_A) && wb_sel_i[1]
      |=> s.ctrl_a[`ADCC_A_WSEL_HI:`ADCC_A_WSEL_LO] == $past(wb_dat_i[11:8]))
    else $error("watch channel select not taken from write");
  AST_COUNT_LOAD: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
    s_start_write ##0 s.state == ADCC_IDLE
      |=> core_run_o && s.remain == $past(s.ctrl_b[`ADCC_B_CNT_HI:`ADCC_B_CNT_LO]))
    else $error("run did not load the conversion count");
  AST_COUNT_STEP: assert property (@(posedge clk_i) disable iff (rst_i) // RL10 RL13
    s.state == ADCC_RUN && tick && !wr_fire && s.remain != 8'h00
      && (s.mode == ADCC_M_SINGLE_MULTI || s.mode == ADCC_M_SEQ_MULTI)
      |=> core_run_o && s.remain == $past(s.remain) - 8'h01)
    else $error("count did not step down");
  AST_SEQ_COUNT_END: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
    s.state == ADCC_RUN && s.mode == ADCC_M_SEQ_MULTI && seq_done_i && !wr_fire
      && s.remain == 8'h00 |=> !core_run_o && s.status[`ADCC_IRQ_FIN])
    else $error("sequence multiple run did not stop at count");
  AST_STATUS_STICKY: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
    s.status[`ADCC_IRQ_WATCH] && !(rd_take && hit(wb_adr_i, `ADCC_OFS_STATUS))
      |=> s.status[`ADCC_IRQ_WATCH])
    else $error("watchdog flag lost without a status read");
  AST_STATUS_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
    rd_take && hit(wb_adr_i, `ADCC_OFS_STATUS) && !watch_hit |=> !s.status[`ADCC_IRQ_WATCH])
    else $error("status read did not clear watchdog flag");
  AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
    irq_o == |(s.status & s.mask))
    else $error("interrupt level does not follow masked status");
  AST_ACC_CLR_ADD: assert property (@(posedge clk_i) disable iff (rst_i) // RL8 RL9
    acc_clr && conv_done_i && s.ctrl_b[`ADCC_B_ACC_EN]
      |=> s.accum == {20'h0, $past(conv_data_i)})
    else $error("clear with result did not leave just that result");
  AST_HIGH_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
    wr_fire && hit(wb_adr_i, `ADCC_OFS_HIGH) && wb_sel_i == 4'hf
      |=> s.high == $past(wb_dat_i[11:0]))
    else $error("high limit not taken from write");
  AST_LOW_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
    wr_fire && hit(wb_adr_i, `ADCC_OFS_LOW) && wb_sel_i == 4'hf
      |=> s.low == $past(wb_dat_i[11:0]))
    else $error("low limit not taken from write");
endmodule
`default_nettype wire

// >>> logic/adcc_map.svh
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
// register byte offsets
`define ADCC_OFS_CTRL_A 8'h04
`define ADCC_OFS_MODE 8'h08
`define ADCC_OFS_CTRL_B 8'h10
`define ADCC_OFS_HIGH 8'h14
`define ADCC_OFS_LOW 8'h18
`define ADCC_OFS_RESULT 8'h40
`define ADCC_OFS_ACCUM 8'h44
`define ADCC_OFS_STATUS 8'h48
`define ADCC_OFS_MASK 8'h4c
// conversion_control_a fields
`define ADCC_A_DMA_CONV 15
`define ADCC_A_DMA_SEQ 14
`define ADCC_A_WATCH_ALL 13
`define ADCC_A_WSEL_HI 11
`define ADCC_A_WSEL_LO 8
`define ADCC_A_ALIGN 6
`define ADCC_A_DISCARD 5
`define ADCC_A_INSEL_HI 3
`define ADCC_A_INSEL_LO 0
`define ADCC_A_MASK 32'h0000ef6f
// conversion_control_b fields
`define ADCC_B_ACC_CLR 9
`define ADCC_B_ACC_EN 8
`define ADCC_B_CNT_HI 7
`define ADCC_B_CNT_LO 0
`define ADCC_B_MASK 32'h000001ff
// mode register fields
`define ADCC_M_MODE_HI 2
`define ADCC_M_MODE_LO 0
`define ADCC_M_START 4
`define ADCC_M_STOP 5
`define ADCC_M_SINGLE_EN 8
`define ADCC_M_BUSY 16
// status and mask bits
`define ADCC_IRQ_W 5
`define ADCC_IRQ_CONV 0
`define ADCC_IRQ_SEQ 1
`define ADCC_IRQ_WATCH 2
`define ADCC_IRQ_OVR 3
`define ADCC_IRQ_FIN 4
// reset values
`define ADCC_CTRL_A_RST 32'h00000000
`define ADCC_CTRL_B_RST 32'h00000000
`define ADCC_HIGH_RST 12'hfff
`define ADCC_LOW_RST 12'h000
`endif

// >>> logic/adcc_pkg.sv
`include "adcc_map.svh"
package adcc_pkg;
  typedef enum logic [1:0] {ADCC_IDLE = 2'b01, ADCC_RUN = 2'b10} adcc_state_t;
  typedef enum logic [2:0] {
    ADCC_M_SINGLE_ONCE = 3'h0, ADCC_M_SINGLE_MULTI = 3'h1, ADCC_M_SINGLE_CONT = 3'h2,
    ADCC_M_SEQ_CONT = 3'h3, ADCC_M_SEQ_SCAN = 3'h4, ADCC_M_SEQ_MULTI = 3'h5,
    ADCC_M_SEQ_PAUSE = 3'h6
  } adcc_mode_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] ctrl_a;
    logic [31:0] ctrl_b;
    logic [2:0] mode;
    logic single_en;
    logic [11:0] high;
    logic [11:0] low;
    logic [31:0] accum;
    logic [`ADCC_IRQ_W-1:0] status;
    logic [`ADCC_IRQ_W-1:0] mask;
    adcc_state_t state;
    logic [7:0] remain;
    logic dma_conv;
    logic dma_seq;
    logic irq;
    logic run;
  } adcc_top_t;
  typedef struct packed {
    logic [15:0] result;
    logic unread;
  } adcc_res_t;
  typedef struct packed {
    logic hit;
  } adcc_wd_t;
endpackage

// >>> logic/adcc_result.sv
`timescale 1ns/1ps
`default_nettype none
// result holder: justification and unread-data policy
module adcc_result
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // new result and policy
  input wire logic store_i,
  input wire logic [11:0] data_i,
  input wire logic align_left_i,
  input wire logic discard_i,
  // software read of the result
  input wire logic read_i,
  // held result
  output logic [15:0] result_o,
  output logic unread_o,
  output logic overrun_o
);
  adcc_res_t s, n;

  // a store in the read cycle keeps unread set, unless discard drops it against an old unread word
  always_comb
  begin
    n = s;
    overrun_o = store_i && s.unread;
    if (read_i)
      n.unread = 1'b0;
    if (store_i && !(s.unread && discard_i)) // RL6
    begin
      n.result = align_left_i ? {data_i, 4'h0} : {4'h0, data_i}; // RL5
      n.unread = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= n;
  end

  assign result_o = s.result;
  assign unread_o = s.unread;

  AST_DISCARD_KEEPS: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
    s.unread && discard_i && store_i |=> $stable(result_o))
    else $error("discard policy overwrote unread result");
  AST_JUSTIFY: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
    store_i && !(s.unread && discard_i) |=>
      result_o == ($past(align_left_i) ? {$past(data_i), 4'h0} : {4'h0, $past(data_i)}))
    else $error("result justification wrong");
endmodule
`default_nettype wire

// >>> logic/adcc_watch.sv
`timescale 1ns/1ps
`default_nettype none
// analog watchdog window compare
module adcc_watch
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration
  input wire logic watch_all_i,
  input wire logic single_en_i,
  input wire logic [3:0] select_i,
  input wire logic [11:0] high_i,
  input wire logic [11:0] low_i,
  // converted result
  input wire logic valid_i,
  input wire logic [3:0] chan_i,
  input wire logic [11:0] data_i,
  // one-cycle hit pulse
  output logic hit_o
);
  adcc_wd_t s, n;
  logic watched;

  // every channel, the one selected channel when single_en_i is set, or no channel is compared
  always_comb
  begin
    watched = watch_all_i || (single_en_i && chan_i == select_i); // RL3 RL4
    n.hit = valid_i && watched && (data_i > high_i || data_i < low_i); // RL14 RL15
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= n;
  end

  assign hit_o = s.hit;

  sequence s_out_of_range;
    valid_i && (data_i > high_i || data_i < low_i);
  endsequence
  AST_WATCH_HIT: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
    ((watch_all_i || (single_en_i && chan_i == select_i)) and s_out_of_range) |=> hit_o)
    else $error("watched out-of-range result not flagged");
  AST_WATCH_QUIET: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
    !watch_all_i && chan_i != select_i |=> !hit_o)
    else $error("unwatched channel flagged");
endmodule
`default_nettype wire

// >>> tb/adcc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// converter core and dma controller stand-in
module adcc_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control from the block, data base from the bench
  input wire logic run_i,
  input wire logic [2:0] mode_i,
  input wire logic [3:0] sel_i,
  input wire logic [11:0] base_i,
  input wire logic dma_conv_i,
  input wire logic dma_seq_i,
  // converter events
  output logic conv_done_o,
  output logic [3:0] chan_o,
  output logic [11:0] data_o,
  output logic seq_done_o,
  // event tallies
  output var int conv_cnt_o,
  output var int seq_cnt_o,
  output var int dma_conv_cnt_o,
  output var int dma_seq_cnt_o
);
  localparam int GAP = 4;
  localparam int SEQ_LEN = 3;
  int gap;
  int idx;
  // one conversion every GAP cycles while a run is on; lines scramble between results
  always_ff @(posedge clk_i)
  begin
    conv_done_o <= 1'b0;
    seq_done_o <= 1'b0;
    if (conv_done_o)
    begin
      chan_o <= ~chan_o;
      data_o <= ~data_o;
    end
    if (conv_done_o && mode_i[2] && idx % SEQ_LEN == 0)
    begin
      seq_done_o <= 1'b1;
      seq_cnt_o <= seq_cnt_o + 1;
    end
    if (dma_conv_i)
      dma_conv_cnt_o <= dma_conv_cnt_o + 1;
    if (dma_seq_i)
      dma_seq_cnt_o <= dma_seq_cnt_o + 1;
    if (rst_i || !run_i)
    begin
      gap <= 0;
      idx <= 0;
    end
    else if (gap == GAP - 1)
    begin
      gap <= 0;
      conv_done_o <= 1'b1;
      chan_o <= mode_i[2] ? 4'(idx % SEQ_LEN) : sel_i;
      data_o <= base_i + 12'(idx);
      idx <= idx + 1;
      conv_cnt_o <= conv_cnt_o + 1;
    end
    else
      gap <= gap + 1;
    if (rst_i)
    begin
      chan_o <= 4'h0;
      data_o <= 12'h000;
      conv_cnt_o <= 0;
      seq_cnt_o <= 0;
      dma_conv_cnt_o <= 0;
      dma_seq_cnt_o <= 0;
    end
  end
endmodule
`default_nettype wire

// >>> tb/adcc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.svh"
module adcc_top_bench;
  import adcc_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, cdone, sdone, run, dmac, dmas, irq;
  logic [7:0] adr;
  logic [3:0] sel, chan, insel;
  logic [31:0] dat, rdat, q;
  logic [11:0] data, base;
  logic [2:0] mode;
  int errors, num_checks, c0, s0, dc0, ds0, cc, sc, dcc, dsc;
  logic [31:0] t_a [7] = '{32'h2000, 32'h2000, 32'h2000, 32'h0303, 32'h0403, 32'h0303, 32'h0f0f};
  logic [8:0] t_m [7] = '{9'h000, 9'h000, 9'h000, 9'h100, 9'h100, 9'h000, 9'h100};
  logic [11:0] t_b [7] = '{12'h100, 12'h080, 12'h008, 12'h100, 12'h100, 12'h100, 12'h100};
  logic [31:0] t_s [7] = '{32'h15, 32'h11, 32'h15, 32'h15, 32'h11, 32'h11, 32'h15};
  adcc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .conv_done_i(cdone), .conv_chan_i(chan), .conv_data_i(data), .seq_done_i(sdone),
    .core_run_o(run), .conv_mode_o(mode), .input_select_o(insel), .dma_conv_req_o(dmac),
    .dma_seq_req_o(dmas), .irq_o(irq));
  adcc_core_model core (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .mode_i(mode),
    .sel_i(insel), .base_i(base), .dma_conv_i(dmac), .dma_seq_i(dmas), .conv_done_o(cdone),
    .chan_o(chan), .data_o(data), .seq_done_o(sdone), .conv_cnt_o(cc), .seq_cnt_o(sc),
    .dma_conv_cnt_o(dcc), .dma_seq_cnt_o(dsc));
  // 50 mhz clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic wishbone cycle; the request holds until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
      errors++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // start a run and wait for it to finish, bounded both ways
  task automatic go(input logic [8:0] m, input logic [11:0] b);
    int n;
    c0 = cc;
    s0 = sc;
    dc0 = dcc;
    ds0 = dsc;
    base <= b;
    bus(1'b1, `ADCC_OFS_MODE, {23'h0, m} | 32'h10);
    n = 0;
    while (run !== 1'b1 && n < 10)
    begin
      @(posedge clk_i);
      n++;
    end
    if (run !== 1'b1)
      errors++;
    n = 0;
    while (run !== 1'b0 && n < 1000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 1000)
      errors++;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the tests take
  initial
  begin
    #400000;
    errors++;
    end_sim;
  end
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    base = 12'h000;
    errors = 0;
    num_checks = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`ADCC_OFS_CTRL_A, 32'h0);
    rd(`ADCC_OFS_CTRL_B, 32'h0);
    rd(`ADCC_OFS_HIGH, 32'h00000fff);
    rd(`ADCC_OFS_LOW, 32'h0);
    rd(8'h20, 32'h0);
    chk(irq, 1'b0);
    // every defined control-register field reads back as written, the clear bit reads zero
    bus(1'b1, `ADCC_OFS_CTRL_A, `ADCC_A_MASK);
    rd(`ADCC_OFS_CTRL_A, `ADCC_A_MASK);
    chk(insel, 4'hf);
    bus(1'b1, `ADCC_OFS_CTRL_B, 32'h000003ff);
    rd(`ADCC_OFS_CTRL_B, 32'h000001ff);
    // single-channel multiple run with accumulation and per-conversion dma
    bus(1'b1, `ADCC_OFS_CTRL_A, 32'h00008005);
    bus(1'b1, `ADCC_OFS_CTRL_B, 32'h00000200);
    bus(1'b1, `ADCC_OFS_CTRL_B, 32'h00000103);
    go(9'h001, 12'h010);
    chk(cc - c0, 32'd4);
    chk(dcc - dc0, 32'd4);
    chk(dsc - ds0, 32'd0);
    chk(insel, 4'h5);
    rd(`ADCC_OFS_ACCUM, 32'h46);
    rd(`ADCC_OFS_RESULT, 32'h13);
    rd(`ADCC_OFS_STATUS, 32'h19);
    bus(1'b1, `ADCC_OFS_CTRL_B, 32'h00000200);
    rd(`ADCC_OFS_ACCUM, 32'h0);
    rd(`ADCC_OFS_CTRL_B, 32'h0);
    // sequence multiple run with sequence dma only
    bus(1'b1, `ADCC_OFS_CTRL_A, 32'h00004000);
    bus(1'b1, `ADCC_OFS_CTRL_B, 32'h00000001);
    go(9'h005, 12'h020);
    chk(sc - s0, 32'd2);
    chk(cc - c0, 32'd6);
    chk(dsc - ds0, 32'd2);
    chk(dcc - dc0, 32'd0);
    rd(`ADCC_OFS_ACCUM, 32'h0);
    bus(1'b0, `ADCC_OFS_RESULT, 32'h0);
    bus(1'b0, `ADCC_OFS_STATUS, 32'h0);
    // unread policy: keep old and left justify, then overwrite
    bus(1'b1, `ADCC_OFS_CTRL_A, 32'h00000060);
    go(9'h001, 12'h123);
    rd(`ADCC_OFS_RESULT, 32'h1230);
    bus(1'b1, `ADCC_OFS_CTRL_A, 32'h0);
    go(9'h001, 12'h123);
    rd(`ADCC_OFS_RESULT, 32'h124);
    bus(1'b0, `ADCC_OFS_STATUS, 32'h0);
    // watchdog window, all-channel and single-channel selection
    bus(1'b1, `ADCC_OFS_HIGH, 32'h000000ff);
    bus(1'b1, `ADCC_OFS_LOW, 32'h00000010);
    rd(`ADCC_OFS_HIGH, 32'h000000ff);
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b1, `ADCC_OFS_CTRL_A, t_a[i]);
      go(t_m[i], t_b[i]);
      rd(`ADCC_OFS_STATUS, t_s[i]);
      bus(1'b0, `ADCC_OFS_RESULT, 32'h0);
    end
    chk(irq, 1'b0);
    // interrupt on run finished, cleared by the status read
    bus(1'b1, `ADCC_OFS_MASK, 32'h00000010);
    go(9'h000, 12'h050);
    chk(irq, 1'b1);
    bus(1'b0, `ADCC_OFS_STATUS, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(irq, 1'b0);
    end_sim;
  end
endmodule
`default_nettype wire
